/* File: core/dma_burst_error_variants.v */
// One DMA channel engine: register slave, AXI read/write master, read buffer.
// Assumes one clock, AXI4-Lite register access, AXI memory side at 128 bits.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "dma_burst_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dma_burst_error_variants #(
  parameter LITE      = 0,
  parameter WIDE_ADDR = 0,
  parameter CHANNEL   = 0,
  parameter BUF_FULL  = 8,
  parameter BUF_LITE  = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Register slave
  input  wire [7:0]   s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output wire         s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output wire         s_axi_wready,
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  input  wire [7:0]   s_axi_araddr,
  input  wire         s_axi_arvalid,
  output wire         s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  // Memory read master
  output reg  [39:0]  m_araddr,
  output reg  [3:0]   m_arlen,
  output reg  [2:0]   m_arsize,
  output reg          m_arvalid,
  input  wire         m_arready,
  input  wire [127:0] m_rdata,
  input  wire [1:0]   m_rresp,
  input  wire         m_rlast,
  input  wire         m_rvalid,
  output wire         m_rready,
  // Memory write master
  output reg  [39:0]  m_awaddr,
  output reg  [3:0]   m_awlen,
  output reg  [2:0]   m_awsize,
  output reg          m_awvalid,
  input  wire         m_awready,
  output wire [127:0] m_wdata,
  output wire [15:0]  m_wstrb,
  output wire         m_wlast,
  output wire         m_wvalid,
  input  wire         m_wready,
  input  wire [1:0]   m_bresp,
  input  wire         m_bvalid,
  output wire         m_bready,
  // Pacing and side signals
  input  wire [31:0]  transfer_request_line,
  input  wire [31:0]  transfer_request_alt,
  input  wire [31:0]  request_line_mux_select,
  input  wire         ext_fifo_error,
  output wire         irq,
  output reg          pcie_path_sel
);

  localparam [0:0] IS_LITE  = (LITE != 0);
  localparam [0:0] IS_WIDE  = (WIDE_ADDR != 0);
  localparam [0:0] HAS_FIFO = (CHANNEL == `FIFO_CH_A) || (CHANNEL == `FIFO_CH_B);
  localparam [3:0] CAP      = IS_LITE ? BUF_LITE[3:0] : BUF_FULL[3:0];
  localparam [2:0] R_IDLE = 3'h1, R_ADDR = 3'h2, R_DATA = 3'h4;
  localparam [3:0] W_IDLE = 4'h1, W_ADDR = 4'h2, W_DATA = 4'h4, W_RESP = 4'h8;

  // Length cut to the variant's field
  function [31:0] len_cut(input [31:0] v);
    begin
      if (IS_LITE)
        len_cut = (v[15:0] == 16'h0000) ? `LEN_LITE_MAX : {16'h0000, v[15:0]};
      else
        len_cut = v & `LEN_FULL_MASK;
    end
  endfunction

  // ********************
  // Register slave
  // ********************
  reg        aw_have_q, w_have_q;
  reg [7:0]  wa_q;
  reg [31:0] wd_q;
  reg [3:0]  ws_q;
  wire       reg_we = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire [31:0] wm  = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire [31:0] wdm = wd_q & wm;
  wire       mapped_w = (wa_q <= `REG_HI) & (wa_q[1:0] == 2'b00);
  wire       mapped_r = (s_axi_araddr <= `REG_HI) & (s_axi_araddr[1:0] == 2'b00);
  reg [31:0] rd_mux;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  function [31:0] merge(input [31:0] old, input [31:0] nw, input [31:0] m);
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  always @(posedge clk) begin
    if (srst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      wa_q         <= 8'h00;
      wd_q         <= 32'h0000_0000;
      ws_q         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        wa_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (reg_we) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped_w ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= mapped_r ? rd_mux : 32'h0000_0000;
        s_axi_rresp  <= mapped_r ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ********************
  // Engine state and derived controls
  // ********************
  reg        active_q, end_q, int_q, rd_err_q, fifo_err_q, last_err_q, drain_q;
  reg [15:0] ti_q, rows_q, rows_left_q;
  reg [31:0] src_q, dst_q, len_q, stride_q, next_q;
  reg [15:0] hi_q;
  reg [31:0] rd_addr_q, wr_addr_q, rd_left_q, wr_left_q;
  reg [2:0]  r_st_q;
  reg [3:0]  w_st_q, cnt_q;
  reg [4:0]  r_beats_q, r_cnt_q, w_beats_q, w_cnt_q;
  reg [31:0] buf_q [0:BUF_FULL-1];
  reg [4:0]  rd_n, wr_n;

  // Lite drops discard and 2D modes
  wire src_disc = ti_q[`TI_SRC_DISC] & ~IS_LITE;
  wire dst_disc = ti_q[`TI_DST_DISC] & ~IS_LITE;
  wire two_dim  = ti_q[`TI_TWO_DIM] & ~IS_LITE;
  wire wide     = ti_q[`TI_WIDE];
  wire [3:0] bw = wide ? 4'h4 : 4'h1;
  wire [4:0] burst_n = {1'b0, ti_q[`TI_BURST_HI:`TI_BURST_LO]} + 5'h01;
  wire [29:0] rd_avail = wide ? {2'b00, rd_left_q[31:4]} : rd_left_q[31:2];
  wire [29:0] wr_avail = wide ? {2'b00, wr_left_q[31:4]} : wr_left_q[31:2];
  wire [3:0]  buf_beats = wide ? {2'b00, cnt_q[3:2]} : cnt_q;

  // Request line selection, line 0 forced high
  wire [31:0] lines = ((request_line_mux_select & transfer_request_alt) |
                      (~request_line_mux_select & transfer_request_line)) | 32'h0000_0001;
  wire req_ok = lines[ti_q[`TI_REQ_HI:`TI_REQ_LO]];

  // Only the wide-address variant reads while writing
  wire r_go = r_st_q[0] & active_q & ~src_disc & (rd_left_q != 32'h0000_0000) &
              req_ok & (IS_WIDE | w_st_q[0]);
  // Hold a lone wide beat while its partner is coming
  wire pair_want = ~IS_WIDE & ~ti_q[`TI_PAIR_OFF] & wide & (CAP >= 4'h8) &
                   (wr_avail >= 30'h0000_0002);
  wire w_go = w_st_q[0] & active_q & ~dst_disc & (wr_left_q != 32'h0000_0000) &
              (src_disc | ((buf_beats != 4'h0) & ~(pair_want & (buf_beats < 4'h2))));

  always @* begin
    rd_n = (rd_avail < {25'h000_0000, burst_n}) ? rd_avail[4:0] : burst_n;
    // Narrow burst limited to what the buffer holds
    if (~wide & ~dst_disc & (rd_n > {1'b0, CAP}))
      rd_n = {1'b0, CAP};
    // Bursts only for zero fill, pairs, or the decoupled variant
    if (src_disc)
      wr_n = (wr_avail < {25'h000_0000, burst_n}) ? wr_avail[4:0] : burst_n;
    else if (IS_WIDE)
      wr_n = (wr_avail < {26'h000_0000, buf_beats}) ? wr_avail[4:0] : {1'b0, buf_beats};
    else
      wr_n = pair_want ? 5'h02 : 5'h01;
  end

  // Stall on a full buffer, never while draining
  assign m_rready = r_st_q[2] & (drain_q | dst_disc | (({1'b0, cnt_q} + {1'b0, bw}) <= {1'b0, CAP}));
  wire r_fire   = m_rvalid & m_rready;
  wire r_last   = (r_cnt_q == r_beats_q - 5'h01);
  wire r_bad    = r_fire & m_rresp[1];
  wire w_fire   = m_wvalid & m_wready;
  wire fill     = r_fire & ~drain_q & ~dst_disc & ~m_rresp[1];
  wire drain    = w_fire & ~src_disc;
  wire idle_all = r_st_q[0] & w_st_q[0] & ~m_arvalid & (cnt_q == 4'h0) &
                  (rd_left_q == 32'h0000_0000) & (dst_disc | (wr_left_q == 32'h0000_0000));
  wire row_next = two_dim & (rows_left_q != 16'h0000);
  wire done     = active_q & idle_all & ~row_next;
  wire row_step = active_q & idle_all & row_next;
  wire cs_we    = reg_we & (wa_q == `REG_CS);
  wire dbg_we   = reg_we & (wa_q == `REG_DEBUG);
  wire [39:0] rd_full = IS_WIDE ? {hi_q[7:0], rd_addr_q} : {5'h00, hi_q[`PAGE_TOP:0], rd_addr_q};
  wire [39:0] wr_full = IS_WIDE ? {hi_q[15:8], wr_addr_q} :
                                  {5'h00, hi_q[8+`PAGE_TOP:8], wr_addr_q};

  // Error bit follows the three flags
  wire err_any = rd_err_q | fifo_err_q | last_err_q;
  assign irq = int_q;

  // Zero data and zero strobes in source-discard mode
  assign m_wvalid = w_st_q[2];
  assign m_wlast  = w_st_q[2] & (w_cnt_q == w_beats_q - 5'h01);
  assign m_bready = w_st_q[3];
  assign m_wdata  = src_disc ? 128'h0 : wide ? {buf_q[3], buf_q[2], buf_q[1], buf_q[0]} :
                    {4{buf_q[0]}};
  assign m_wstrb  = src_disc ? 16'h0000 : wide ? 16'hffff :
                    (16'h000f << {wr_addr_q[3:2], 2'b00});

  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `REG_CS: begin
        rd_mux[`CS_ACTIVE] = active_q;
        rd_mux[`CS_END]    = end_q;
        rd_mux[`CS_INT]    = int_q;
        rd_mux[`CS_ERROR]  = err_any;
      end
      `REG_TI:     rd_mux = {16'h0000, ti_q};
      `REG_SRC:    rd_mux = src_q;
      `REG_DST:    rd_mux = dst_q;
      `REG_LEN:    rd_mux = len_q;
      `REG_STRIDE: rd_mux = stride_q;
      `REG_ROWS:   rd_mux = {16'h0000, rows_q};
      `REG_DEBUG: begin
        rd_mux[`DBG_RD_ERR]   = rd_err_q;
        rd_mux[`DBG_FIFO_ERR] = fifo_err_q;
        rd_mux[`DBG_LAST_ERR] = last_err_q;
      end
      `REG_NEXT:   rd_mux = next_q;
      `REG_HI:     rd_mux = {16'h0000, hi_q};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // ********************
  // Read buffer
  // ********************
  integer i;
  always @(posedge clk) begin
    if (srst || (reg_we && wa_q == `REG_LEN)) begin
      cnt_q <= 4'h0;
      for (i = 0; i < BUF_FULL; i = i + 1)
        buf_q[i] <= 32'h0000_0000;
    end else begin
      for (i = 0; i < BUF_FULL; i = i + 1) begin
        if (drain)
          buf_q[i] <= (i + bw < BUF_FULL) ? buf_q[i + bw] : 32'h0000_0000;
        if (fill && i >= cnt_q - (drain ? bw : 4'h0) &&
            i < cnt_q - (drain ? bw : 4'h0) + bw)
          buf_q[i] <= m_rdata[32 * (i - (cnt_q - (drain ? bw : 4'h0))) +: 32];
      end
      cnt_q <= cnt_q + (fill ? bw : 4'h0) - (drain ? bw : 4'h0);
    end
  end

  // ********************
  // Registers, read and write sequencing, flags
  // ********************
  always @(posedge clk) begin
    if (srst) begin
      active_q <= 1'b0; end_q <= 1'b0; int_q <= 1'b0; drain_q <= 1'b0;
      rd_err_q <= 1'b0; fifo_err_q <= 1'b0; last_err_q <= 1'b0;
      ti_q <= 16'h0000; rows_q <= 16'h0000; rows_left_q <= 16'h0000; hi_q <= 16'h0000;
      src_q <= 32'h0000_0000; dst_q <= 32'h0000_0000; len_q <= 32'h0000_0000;
      stride_q <= 32'h0000_0000; next_q <= 32'h0000_0000;
      rd_addr_q <= 32'h0000_0000; wr_addr_q <= 32'h0000_0000;
      rd_left_q <= 32'h0000_0000; wr_left_q <= 32'h0000_0000;
      r_st_q <= R_IDLE; w_st_q <= W_IDLE;
      r_beats_q <= 5'h00; r_cnt_q <= 5'h00; w_beats_q <= 5'h00; w_cnt_q <= 5'h00;
      m_araddr <= 40'h00_0000_0000; m_arlen <= 4'h0; m_arsize <= `SIZE_NARROW;
      m_arvalid <= 1'b0;
      m_awaddr <= 40'h00_0000_0000; m_awlen <= 4'h0; m_awsize <= `SIZE_NARROW;
      m_awvalid <= 1'b0; pcie_path_sel <= 1'b0;
    end else begin
      // PCIe path only on channel 11
      pcie_path_sel <= (CHANNEL == `PCIE_CHANNEL) &
                       (hi_q[`HI_PCIE_BIT] | hi_q[8+`HI_PCIE_BIT]);
      if (reg_we) begin
        case (wa_q)
          `REG_CS: begin
            if (ws_q[0])
              active_q <= wd_q[`CS_ACTIVE];
            // Abort ends the transfer at the next idle point
            if (wdm[`CS_ABORT]) begin
              rd_left_q   <= 32'h0000_0000;
              wr_left_q   <= 32'h0000_0000;
              rows_left_q <= 16'h0000;
            end
          end
          `REG_TI:     ti_q <= ((ti_q & ~wm[15:0]) | (wd_q[15:0] & wm[15:0])) &
                               (IS_LITE ? `TI_LITE_KEEP : 16'hffff);
          `REG_SRC:    src_q <= merge(src_q, wd_q, wm);
          `REG_DST:    dst_q <= merge(dst_q, wd_q, wm);
          `REG_LEN: begin
            len_q       <= merge(len_q, wd_q, wm) & (IS_LITE ? 32'h0000_ffff : `LEN_FULL_MASK);
            rd_addr_q   <= src_q;
            wr_addr_q   <= dst_q;
            rd_left_q   <= src_disc ? 32'h0000_0000 : len_cut(merge(len_q, wd_q, wm));
            wr_left_q   <= len_cut(merge(len_q, wd_q, wm));
            rows_left_q <= rows_q;
          end
          // Two-dimensional settings ignored on the lite engine
          `REG_STRIDE: stride_q <= IS_LITE ? 32'h0000_0000 : merge(stride_q, wd_q, wm);
          `REG_ROWS:   rows_q <= IS_LITE ? 16'h0000 : (rows_q & ~wm[15:0]) | (wd_q[15:0] & wm[15:0]);
          `REG_NEXT:   next_q <= merge(next_q, wd_q, wm);
          `REG_HI:     hi_q <= (hi_q & ~wm[15:0]) | (wd_q[15:0] & wm[15:0]);
          default: ;
        endcase
      end
      if (row_step) begin
        rd_addr_q   <= rd_addr_q + {{16{stride_q[15]}}, stride_q[15:0]};
        wr_addr_q   <= wr_addr_q + {{16{stride_q[31]}}, stride_q[31:16]};
        rd_left_q   <= src_disc ? 32'h0000_0000 : len_cut(len_q);
        wr_left_q   <= len_cut(len_q);
        rows_left_q <= rows_left_q - 16'h0001;
      end
      // Launch only after sampling the request line high
      if (r_go) begin
        m_araddr  <= rd_full;
        m_arlen   <= rd_n[3:0] - 4'h1;
        m_arsize  <= wide ? `SIZE_WIDE : `SIZE_NARROW;
        m_arvalid <= 1'b1;
        r_beats_q <= rd_n;
        r_cnt_q   <= 5'h00;
        rd_addr_q <= rd_addr_q + (wide ? {23'h00_0000, rd_n, 4'h0} : {25'h000_0000, rd_n, 2'h0});
        rd_left_q <= rd_left_q - (wide ? {23'h00_0000, rd_n, 4'h0} : {25'h000_0000, rd_n, 2'h0});
        r_st_q    <= R_ADDR;
      end
      if (r_st_q[1] && m_arready) begin
        m_arvalid <= 1'b0;
        r_st_q    <= R_DATA;
      end
      if (r_fire) begin
        r_cnt_q <= r_cnt_q + 5'h01;
        // Failed burst runs out with data dropped
        if (m_rresp[1])
          drain_q <= 1'b1;
        if (r_last) begin
          drain_q <= 1'b0;
          r_st_q  <= R_IDLE;
        end
      end
      if (w_go) begin
        m_awaddr  <= wr_full;
        m_awlen   <= wr_n[3:0] - 4'h1;
        m_awsize  <= wide ? `SIZE_WIDE : `SIZE_NARROW;
        m_awvalid <= 1'b1;
        w_beats_q <= wr_n;
        w_cnt_q   <= 5'h00;
        w_st_q    <= W_ADDR;
      end
      if (w_st_q[1] && m_awready) begin
        m_awvalid <= 1'b0;
        w_st_q    <= W_DATA;
      end
      if (w_fire) begin
        w_cnt_q   <= w_cnt_q + 5'h01;
        wr_addr_q <= wr_addr_q + (wide ? 32'h0000_0010 : 32'h0000_0004);
        wr_left_q <= wr_left_q - (wide ? 32'h0000_0010 : 32'h0000_0004);
        if (m_wlast)
          w_st_q <= W_RESP;
      end
      if (w_st_q[3] && m_bvalid)
        w_st_q <= W_IDLE;
      // Read error or completion stops the channel and interrupts
      if (r_bad || done)
        active_q <= 1'b0;
      end_q <= done | (end_q & ~(cs_we & wdm[`CS_END]));
      int_q <= r_bad | done | (int_q & ~(cs_we & wdm[`CS_INT]));
      // Sticky error, cleared only by writing one
      rd_err_q <= r_bad | (rd_err_q & ~(dbg_we & wdm[`DBG_RD_ERR]));
      // External FIFO error on fitted channels only
      fifo_err_q <= (HAS_FIFO & ext_fifo_error) |
                    (fifo_err_q & ~(dbg_we & wdm[`DBG_FIFO_ERR]));
      last_err_q <= (r_fire & r_last & ~m_rlast) |
                    (last_err_q & ~(dbg_we & wdm[`DBG_LAST_ERR]));
    end
  end

endmodule

`default_nettype wire

/* File: core/dma_burst_map.vh */
// Register offsets, field positions and codes for the DMA channel engine.
// Assumes inclusion by bare name from the engine source file.
`ifndef DMA_BURST_MAP_VH
`define DMA_BURST_MAP_VH

// ********************
// Register offsets (byte addresses)
// ********************
`define REG_CS      8'h00
`define REG_TI      8'h04
`define REG_SRC     8'h08
`define REG_DST     8'h0c
`define REG_LEN     8'h10
`define REG_STRIDE  8'h14
`define REG_ROWS    8'h18
`define REG_DEBUG   8'h1c
`define REG_NEXT    8'h20
`define REG_HI      8'h24

// ********************
// Field positions
// ********************
`define CS_ACTIVE    0
`define CS_END       1
`define CS_INT       2
`define CS_ERROR     3
`define CS_ABORT     4
`define TI_SRC_DISC  0
`define TI_DST_DISC  1
`define TI_TWO_DIM   2
`define TI_PAIR_OFF  3
`define TI_WIDE      4
`define TI_REQ_LO    5
`define TI_REQ_HI    9
`define TI_BURST_LO  12
`define TI_BURST_HI  15
`define DBG_RD_ERR   0
`define DBG_FIFO_ERR 1
`define DBG_LAST_ERR 2
`define HI_PCIE_BIT  7
`define PAGE_TOP     2

// ********************
// Codes, masks and fixed figures
// ********************
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define SIZE_NARROW   3'h2
`define SIZE_WIDE     3'h4
`define TI_LITE_KEEP  16'hfff8
`define LEN_LITE_MAX  32'h0001_0000
`define LEN_FULL_MASK 32'h3fff_ffff
`define PCIE_CHANNEL  11
`define FIFO_CH_A     0
`define FIFO_CH_B     15

`endif

/* File: testbench/dma_burst_checker_props.sv */
// Port-level assertions and covers for the DMA channel engine.
// Assumes binding to the engine top with the same parameters.
`timescale 1ns/1ps
`default_nettype none
module dma_burst_checker #(
  parameter LITE      = 0,
  parameter WIDE_ADDR = 0,
  parameter CHANNEL   = 0,
  parameter BUF_FULL  = 8,
  parameter BUF_LITE  = 4
) (
  // Clock, reset and register read channel
  input wire logic        clk, srst, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // Memory read
  input wire logic [3:0]  m_arlen,
  input wire logic [2:0]  m_arsize,
  input wire logic        m_arvalid, m_arready, m_rlast, m_rvalid, m_rready,
  input wire logic [1:0]  m_rresp,
  // Memory write
  input wire logic [3:0]  m_awlen,
  input wire logic [15:0] m_wstrb,
  input wire logic        m_awvalid, m_awready, m_wlast, m_wvalid, m_wready,
  // Side outputs
  input wire logic        irq, pcie_path_sel
);
  localparam int CAP = LITE ? BUF_LITE : BUF_FULL;
  logic       rd_busy_q;
  logic [3:0] aw_len_q;
  logic [3:0] wcnt_q;
  // Tracks the open read burst and the beat index of the open write burst
  always @(posedge clk) begin
    if (srst) begin
      rd_busy_q <= 1'h0;
      aw_len_q  <= 4'h0;
      wcnt_q    <= 4'h0;
    end else begin
      if (m_arvalid && m_arready) rd_busy_q <= 1'h1;
      else if (m_rvalid && m_rready && m_rlast) rd_busy_q <= 1'h0;
      if (m_awvalid && m_awready) aw_len_q <= m_awlen;
      if (m_awvalid && m_awready) wcnt_q <= 4'h0;
      else if (m_wvalid && m_wready) wcnt_q <= wcnt_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_ar_single: assert property (m_arvalid |-> !rd_busy_q)
    else $error("read burst overlap");
  a_ar_hold: assert property (m_arvalid && !m_arready |=> m_arvalid && $stable(m_arlen))
    else $error("read address not held");
  a_narrow_fits: assert property (m_arvalid && m_arsize == 3'h2 |-> m_arlen < CAP)
    else $error("narrow burst too long");
  a_error_irq: assert property (m_rvalid && m_rready && m_rresp != 2'h0 |-> ##[1:20] irq)
    else $error("no irq after read error");
  a_err_drain: assert property (m_rvalid && m_rready && m_rresp != 2'h0 && !m_rlast
    |=> !m_rvalid || m_rready)
    else $error("error burst stalled");
  a_wlast_count: assert property (m_wvalid && m_wready |-> m_wlast == (wcnt_q == aw_len_q))
    else $error("wlast misplaced");
  a_wr_burst_cap: assert property (m_wvalid && m_wstrb != 16'h0000 && WIDE_ADDR == 0
    |-> aw_len_q <= 4'h1)
    else $error("write burst too long");
  a_pcie_only: assert property (CHANNEL != 11 |-> !pcie_path_sel)
    else $error("PCIe path off channel");
  a_reg_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_read_error: cover property (m_rvalid && m_rready && m_rresp == 2'h2);
  c_pair_burst: cover property (m_awvalid && m_awready && m_awlen == 4'h1);
  c_full_narrow: cover property (m_arvalid && m_arready && m_arlen == 4'h7);
endmodule
`default_nettype wire

/* File: testbench/mem_model.sv */
// Memory-side model: read data source and write sink with traffic counts.
// Assumes one read burst and one write burst open at a time.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock, reset and test controls
  input  wire logic         clk, srst, err_first, drop_last, slow,
  // Read address and data
  input  wire logic         m_arvalid, m_rready,
  input  wire logic [3:0]   m_arlen,
  output logic              m_arready, m_rlast, m_rvalid,
  output logic [1:0]        m_rresp,
  output logic [127:0]      m_rdata,
  // Write address, data and response
  input  wire logic         m_awvalid, m_wvalid, m_wlast, m_bready,
  input  wire logic [3:0]   m_awlen,
  output logic              m_awready, m_wready, m_bvalid,
  output logic [1:0]        m_bresp,
  // Traffic counts
  output logic [7:0]        ar_count, rbeats, wbeats,
  output logic [3:0]        max_arlen, max_awlen
);
  logic [4:0] left_q;
  logic [3:0] beat_q;
  logic       ph_q, wbusy_q;
  assign m_arready = left_q == 5'h00;
  assign m_rvalid  = left_q != 5'h00 && (ph_q || !slow);
  assign m_rlast   = left_q == 5'h01 && !drop_last;
  assign m_rresp   = (err_first && beat_q == 4'h0) ? 2'h2 : 2'h0;
  // Idle data lines swing away from the last beat
  assign m_rdata   = m_rvalid ? {4{28'h000_0000, beat_q}} : {4{28'hfff_ffff, ~beat_q}};
  assign m_awready = !wbusy_q && !m_bvalid;
  assign m_wready  = wbusy_q;
  assign m_bresp   = 2'h0;
  always @(posedge clk) begin
    if (srst) begin
      {left_q, beat_q, ph_q, wbusy_q, m_bvalid} <= '0;
      {ar_count, rbeats, wbeats, max_arlen, max_awlen} <= '0;
    end else begin
      if (!m_rvalid || m_rready) ph_q <= !ph_q;
      if (m_arvalid && m_arready) begin
        left_q   <= {1'h0, m_arlen} + 5'h01;
        beat_q   <= 4'h0;
        ar_count <= ar_count + 8'h01;
        if (m_arlen > max_arlen) max_arlen <= m_arlen;
      end
      if (m_rvalid && m_rready) begin
        left_q <= left_q - 5'h01;
        beat_q <= beat_q + 4'h1;
        rbeats <= rbeats + 8'h01;
      end
      if (m_awvalid && m_awready) begin
        wbusy_q <= 1'h1;
        if (m_awlen > max_awlen) max_awlen <= m_awlen;
      end
      if (m_wvalid && m_wready) wbeats <= wbeats + 8'h01;
      if (m_wvalid && m_wready && m_wlast) wbusy_q <= 1'h0;
      if (m_wvalid && m_wready && m_wlast) m_bvalid <= 1'h1;
      else if (m_bvalid && m_bready) m_bvalid <= 1'h0;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for one normal DMA channel engine on channel 0.
// Assumes the engine, the map header, the checker and the memory model.
`include "dma_burst_map.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0, srst = 1'h1, err_first = 1'h0, drop_last = 1'h0, slow = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rd_d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_fifo_error = 1'h0;
  logic [31:0] transfer_request_line = 32'h0000_0000, transfer_request_alt = 32'h0000_0000;
  logic [31:0] request_line_mux_select = 32'h0000_0000;
  logic [1:0]  rd_r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp, m_rresp, m_bresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] m_arlen, m_awlen, max_arlen, max_awlen;
  wire [127:0] m_rdata;
  wire m_arvalid, m_arready, m_rlast, m_rvalid, m_rready, m_awvalid, m_awready;
  wire m_wlast, m_wvalid, m_wready, m_bvalid, m_bready;
  wire [7:0] ar_count, rbeats, wbeats;
  int mismatches = 0, check_count = 0, cycles = 0;
  dma_burst_error_variants dut_u (.*, .m_araddr(), .m_arsize(), .m_awaddr(), .m_awsize(),
    .m_wdata(), .m_wstrb(), .pcie_path_sel());
  mem_model mem_u (.*);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  // ********************
  // Register bus and checking tasks
  // ********************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge clk);
      {ha, hw, hb} = {s_axi_awready, s_axi_wready, s_axi_bvalid === 1'h1};
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      if (hb) s_axi_bready <= 1'h0;
    end while (!hb);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge clk);
      {ha, hr, rd_d, rd_r} = {s_axi_arready, s_axi_rvalid === 1'h1, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'h0;
      if (hr) s_axi_rready <= 1'h0;
    end while (!hr);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rd_d & m);
  endtask
  task automatic run(input logic [31:0] ti, input logic [31:0] len);
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    wr(`REG_TI, ti);
    wr(`REG_SRC, 32'h0000_0100);
    wr(`REG_DST, 32'h0000_1000);
    wr(`REG_LEN, len);
    wr(`REG_CS, 32'h0000_0001);
  endtask
  task automatic settle();
    int n;
    n = 0;
    do begin
      repeat (10) @(posedge clk);
      rd(`REG_CS);
      n++;
    end while (rd_d[0] !== 1'h0 && n < 40);
    chk("idle", 32'h0000_0000, 32'(rd_d[0]));
  endtask
  // ********************
  // Scenarios
  // ********************
  initial begin
    run(32'h0000_1010, 32'h0000_0040);
    settle();
    chk("write beats", 32'h0000_0004, 32'(wbeats));
    chk("paired awlen", 32'h0000_0001, 32'(max_awlen));
    run(32'h0000_1018, 32'h0000_0040);
    settle();
    chk("unpaired awlen", 32'h0000_0000, 32'(max_awlen));
    slow <= 1'h1;
    run(32'h0000_f000, 32'h0000_0040);
    settle();
    chk("narrow arlen", 32'h0000_0007, 32'(max_arlen));
    chk("narrow awlen", 32'h0000_0000, 32'(max_awlen));
    {slow, err_first} <= 2'h1;
    run(32'h0000_7000, 32'h0000_0020);
    for (int i = 0; i < 200 && irq !== 1'h1; i++) @(posedge clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    settle();
    rchk(`REG_CS, 32'h0000_0009, 32'h0000_0008);
    chk("read beats", 32'h0000_0008, 32'(rbeats));
    rchk(`REG_DEBUG, 32'h0000_0007, 32'h0000_0001);
    wr(`REG_DEBUG, 32'h0000_0000);
    rchk(`REG_DEBUG, 32'h0000_0007, 32'h0000_0001);
    wr(`REG_DEBUG, 32'h0000_0001);
    rchk(`REG_DEBUG, 32'h0000_0007, 32'h0000_0000);
    err_first <= 1'h0;
    wr(`REG_CS, 32'h0000_0011);
    settle();
    rchk(`REG_CS, 32'h0000_0008, 32'h0000_0000);
    drop_last <= 1'h1;
    run(32'h0000_3000, 32'h0000_0010);
    settle();
    rchk(`REG_DEBUG, 32'h0000_0004, 32'h0000_0004);
    rchk(`REG_CS, 32'h0000_0008, 32'h0000_0008);
    {drop_last, ext_fifo_error} <= 2'h1;
    @(posedge clk);
    ext_fifo_error <= 1'h0;
    rchk(`REG_DEBUG, 32'h0000_0002, 32'h0000_0002);
    wr(`REG_DEBUG, 32'h0000_0006);
    rchk(`REG_DEBUG, 32'h0000_0007, 32'h0000_0000);
    rd(8'h80);
    chk("unmapped resp", 32'h0000_0002, 32'(rd_r));
    transfer_request_alt <= 32'h0000_0008;
    run(32'h0000_0060, 32'h0000_0010);
    repeat (20) @(posedge clk);
    chk("paced reads", 32'h0000_0000, 32'(ar_count));
    request_line_mux_select <= 32'h0000_0008;
    settle();
    chk("alt reads", 32'h0000_0004, 32'(ar_count));
    end_sim();
  end
endmodule
bind dma_burst_error_variants dma_burst_checker #(.LITE(LITE), .WIDE_ADDR(WIDE_ADDR),
  .CHANNEL(CHANNEL), .BUF_FULL(BUF_FULL), .BUF_LITE(BUF_LITE)) chk_u (.*);
`default_nettype wire
